// >>> src/ssl_regs.sv
// Sense result, switch state and status lamp registers of a quad switch
//
// Notes on behaviour
// R01: Channel 4 output voltage result is a read-only byte at 0x1a, reset 0.
// R02: Upper eight supply voltage result bits read at 0x1b, reset 0.
// R03: Lowest two supply voltage bits sit in bits 1:0 of 0x1c, rest read 0.
// R04: Bits 3:0 of 0x1d switch channels 4..1 on when 1; bits 7:4 read 0.
// R05: A write to 0x1d takes the state from the data byte, not frame bits.
// R06: All switch state bits are zero after reset, every channel off.
// R07: Bits 0..3 of 0x1e light status lamps 1..4 when 1; bits 7:4 reserved.
// R08: The lamp control byte resets to zero, all lamps off.
// R09: Writes to read-only results or reserved bits leave them unchanged; valid frame switch bits still apply.
`timescale 1ns/1ps

module ssl_regs
  import ssl_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  // Register access from the frame decoder (same clock)
  input  wire logic                    reg_req_i,
  input  wire logic                    reg_we_i,
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [SSL_DATA_W-1:0]   reg_wdata_i,
  input  wire logic                    frame_sw_valid_i,
  input  wire logic [SSL_NUM_CH-1:0]   frame_sw_i,
  output logic      [SSL_DATA_W-1:0]   reg_rdata_o,
  output logic                         reg_rvalid_o,
  // Converter results (same clock)
  input  wire logic                    conv_ch4_load_i,
  input  wire logic [SSL_RESULT_W-1:0] conv_ch4_code_i,
  input  wire logic                    conv_vs_load_i,
  input  wire logic [SSL_VS_W-1:0]     conv_vs_code_i,
  // Outputs to the power stage and lamp drivers
  output logic      [SSL_NUM_CH-1:0]   chan_enable_o,
  output logic      [SSL_NUM_LAMP-1:0] lamp_drive_o
);

  // ==========================================================================
  // Address decoding, shared by the read and write paths
  function automatic ssl_sel_e ssl_decode(input logic [7:0] addr);
    ssl_sel_e sel;
    sel = SSL_SEL_NONE;
    case (addr)
      SSL_OFS_CH4_VOLT: sel = SSL_SEL_CH4_VOLT;
      SSL_OFS_VS_HIGH:  sel = SSL_SEL_VS_HIGH;
      SSL_OFS_VS_LOW:   sel = SSL_SEL_VS_LOW;
      SSL_OFS_OUTPUT_SWITCH_STATE: sel = SSL_SEL_OUTPUT_SWITCH_STATE;
      SSL_OFS_LAMP_CTL: sel = SSL_SEL_LAMP_CTL;
      default:          sel = SSL_SEL_NONE;
    endcase
    return sel;
  endfunction

  // ==========================================================================
  // Converter result holding registers
  logic [SSL_RESULT_W-1:0] ch4_code;
  logic [SSL_VS_W-1:0]     vs_code;

  // Channel 4 output voltage result
  ssl_result_hold #(
    .WIDTH  (SSL_RESULT_W)
  ) u_ch4_hold (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .load_i (conv_ch4_load_i),
    .code_i (conv_ch4_code_i),
    .code_o (ch4_code)
  );

  // Supply voltage result, all ten bits held together so both bytes match
  ssl_result_hold #(
    .WIDTH  (SSL_VS_W)
  ) u_vs_hold (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .load_i (conv_vs_load_i),
    .code_i (conv_vs_code_i),
    .code_o (vs_code)
  );

  // ==========================================================================
  // Block state
  typedef struct packed {
    logic [SSL_NUM_CH-1:0]   sw;
    logic [SSL_NUM_LAMP-1:0] lamp;
    logic [SSL_DATA_W-1:0]   rdata;
    logic                    rvalid;
  } ssl_state_s;

  ssl_state_s state_reg;
  ssl_state_s state_next;
  ssl_sel_e   req_sel;

  assign req_sel = ssl_decode(reg_addr_i);

  // ==========================================================================
  // Next state: writes, frame switch bits and read data
  always_comb
  begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    if (reg_req_i)
    begin
      // Frame switch bits apply only when this frame is not a switch write
      if (frame_sw_valid_i &&
          !(reg_we_i && req_sel == SSL_SEL_OUTPUT_SWITCH_STATE))   // R05
      begin
        state_next.sw = frame_sw_i;
      end
      if (reg_we_i)
      begin
        case (req_sel)
          SSL_SEL_OUTPUT_SWITCH_STATE:
          begin
            // Data byte only; upper bits dropped as reserved
            state_next.sw = reg_wdata_i[SSL_NUM_CH-1:0];     // R04 R05
          end
          SSL_SEL_LAMP_CTL:
          begin
            state_next.lamp = reg_wdata_i[SSL_NUM_LAMP-1:0]; // R07
          end
          default:
          begin
            // Results and unmapped bytes ignore writes
            state_next.lamp = state_reg.lamp;                // R09
          end
        endcase
      end
      else
      begin
        state_next.rvalid = 1'b1;
        case (req_sel)
          SSL_SEL_CH4_VOLT:
          begin
            state_next.rdata = ch4_code;                     // R01
          end
          SSL_SEL_VS_HIGH:
          begin
            state_next.rdata = vs_code[SSL_VS_W-1:SSL_VS_LSB_W]; // R02
          end
          SSL_SEL_VS_LOW:
          begin
            state_next.rdata = {6'h00, vs_code[SSL_VS_LSB_W-1:0]}; // R03
          end
          SSL_SEL_OUTPUT_SWITCH_STATE:
          begin
            state_next.rdata = {4'h0, state_reg.sw};         // R04
          end
          SSL_SEL_LAMP_CTL:
          begin
            state_next.rdata = {4'h0, state_reg.lamp};       // R07
          end
          default:
          begin
            state_next.rdata = SSL_RDATA_UNMAP;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // State register; everything off after reset
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg.sw     <= SSL_RST_OUTPUT_SWITCH_STATE;  // R06
      state_reg.lamp   <= SSL_RST_LAMP;      // R08
      state_reg.rdata  <= SSL_RST_RESULT;
      state_reg.rvalid <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register
  assign chan_enable_o = state_reg.sw;
  assign lamp_drive_o  = state_reg.lamp;
  assign reg_rdata_o   = state_reg.rdata;
  assign reg_rvalid_o  = state_reg.rvalid;

endmodule

// >>> src/ssl_pkg.sv
// Package: register map, field layout and reset values of the sense/lamp bank
package ssl_pkg;

  // ==========================================================================
  // Register offsets (byte-wide registers, 8-bit address)
  localparam logic [7:0] SSL_OFS_CH4_VOLT   = 8'h1a;
  localparam logic [7:0] SSL_OFS_VS_HIGH    = 8'h1b;
  localparam logic [7:0] SSL_OFS_VS_LOW     = 8'h1c;
  localparam logic [7:0] SSL_OFS_OUTPUT_SWITCH_STATE   = 8'h1d;
  localparam logic [7:0] SSL_OFS_LAMP_CTL   = 8'h1e;

  // ==========================================================================
  // Field layout
  localparam int SSL_DATA_W      = 8;
  localparam int SSL_NUM_CH      = 4;
  localparam int SSL_NUM_LAMP    = 4;
  localparam int SSL_RESULT_W    = 8;
  localparam int SSL_VS_W        = 10;
  localparam int SSL_VS_LSB_W    = 2;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SSL_RST_RESULT   = 8'h00;
  localparam logic [3:0] SSL_RST_OUTPUT_SWITCH_STATE = 4'h0;
  localparam logic [3:0] SSL_RST_LAMP     = 4'h0;
  localparam logic [7:0] SSL_RDATA_UNMAP  = 8'h00;

  // ==========================================================================
  // Register selector decoded from an address
  typedef enum {
    SSL_SEL_CH4_VOLT,
    SSL_SEL_VS_HIGH,
    SSL_SEL_VS_LOW,
    SSL_SEL_OUTPUT_SWITCH_STATE,
    SSL_SEL_LAMP_CTL,
    SSL_SEL_NONE
  } ssl_sel_e;

endpackage

// >>> src/ssl_result_hold.sv
// Holding register for one converter result, loaded by a valid strobe
`timescale 1ns/1ps

module ssl_result_hold
  import ssl_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] code_i,
  output logic      [WIDTH-1:0] code_o
);

  typedef struct packed {
    logic [WIDTH-1:0] code;
  } ssl_hold_s;

  ssl_hold_s state_reg;
  ssl_hold_s state_next;

  // ==========================================================================
  // Next value: only a converter strobe replaces the held code
  always_comb
  begin
    state_next = state_reg;
    if (load_i)
    begin
      state_next.code = code_i;
    end
  end

  // Register; host writes never reach this module, so results stay read-only
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign code_o = state_reg.code;

endmodule

// >>> dv/ssl_regs_asserts.sv
// Checker: port properties of the sense and lamp register bank
`timescale 1ns/1ps
// ====
// Assertions on the bank ports
module ssl_regs_asserts
  import ssl_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       reg_req_i,
  input wire logic       reg_we_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       frame_sw_valid_i,
  input wire logic [3:0] frame_sw_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic [3:0] chan_enable_o,
  input wire logic [3:0] lamp_drive_o
);
  // Decoded request kinds
  wire       rd = reg_req_i & !reg_we_i;
  wire       sw = reg_req_i & reg_we_i & (reg_addr_i == SSL_OFS_OUTPUT_SWITCH_STATE);
  wire       lp = reg_req_i & reg_we_i & (reg_addr_i == SSL_OFS_LAMP_CTL);
  wire [3:0] wd = reg_wdata_i[3:0];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_read_valid: assert property (rd |=> reg_rvalid_o)
    else $error("read gave no valid");
  a_sw_write: assert property (sw |=> chan_enable_o == $past(wd))
    else $error("switch write lost");
  a_sw_frame: assert property (
    reg_req_i && frame_sw_valid_i && !sw
    |=> chan_enable_o == $past(frame_sw_i))
    else $error("frame bits not applied");
  a_sw_hold: assert property (!reg_req_i |=> $stable(chan_enable_o))
    else $error("switch state moved");
  a_lamp_write: assert property (lp |=> lamp_drive_o == $past(wd))
    else $error("lamp write lost");
  a_lamp_hold: assert property (!lp |=> $stable(lamp_drive_o))
    else $error("lamp state moved");
  a_sw_readback: assert property (
    rd && reg_addr_i == SSL_OFS_OUTPUT_SWITCH_STATE
    |=> reg_rdata_o == {4'h0, $past(chan_enable_o)})
    else $error("switch readback wrong");
  a_vs_low_rsvd: assert property (
    rd && reg_addr_i == SSL_OFS_VS_LOW
    |=> reg_rdata_o[7:2] == 6'h00)
    else $error("reserved bits set");
  // Valid is a single-cycle pulse; data stands until the next read
  a_rvalid_pulse: assert property (!rd |=> !reg_rvalid_o)
    else $error("read valid without read");
  a_rdata_hold: assert property (!rd |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
endmodule

// >>> dv/ssl_host.sv
// Host model: frame decoder side issuing register requests
`timescale 1ns/1ps
// ====
// Requester, drives on falling edges
module ssl_host
  import ssl_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic            req_o,
  output logic            we_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            fsv_o,
  output logic      [3:0] fsw_o
);
  initial {req_o, we_o, addr_o, wdata_o, fsv_o, fsw_o} = '0;
  // One-cycle request; released qualifiers flip so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      input logic [4:0] f, output logic [7:0] q);
    int n;
    @(negedge mclk_i);
    {req_o, we_o, addr_o, wdata_o, fsv_o, fsw_o} = {1'b1, w, a, d, f};
    @(negedge mclk_i);
    req_o = 1'b0;
    {we_o, addr_o, wdata_o} = ~{we_o, addr_o, wdata_o};
    {fsv_o, fsw_o} = ~{fsv_o, fsw_o};
    q = rdata_i;
    for (n = 0; !w && rvalid_i !== 1'b1; n++)
    begin
      if (n == 4)
      begin
        ssl_regs_tb.fails++;
        ssl_regs_tb.report_and_stop();
      end
      @(negedge mclk_i);
      q = rdata_i;
    end
  endtask
endmodule

// >>> dv/ssl_regs_tb.sv
// Testbench: reset values, results, switch and lamp registers
`timescale 1ns/1ps
// ====
// Bench top
module ssl_regs_tb;
  import ssl_pkg::*;
  logic       mclk_i = 1'b0, rst_i = 1'b1, reg_rvalid_o;
  logic       reg_req_i, reg_we_i, frame_sw_valid_i;
  logic       conv_ch4_load_i = 1'b0, conv_vs_load_i = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
  logic [7:0] conv_ch4_code_i = 8'h00;
  logic [9:0] conv_vs_code_i = 10'h000;
  logic [3:0] frame_sw_i, chan_enable_o, lamp_drive_o;
  logic [7:0] exp [3];
  int         fails = 0;
  int         samples_checked = 0;
  always #10 mclk_i = ~mclk_i;
  ssl_regs DUT (
    .mclk_i           (mclk_i),
    .rst_i            (rst_i),
    .reg_req_i        (reg_req_i),
    .reg_we_i         (reg_we_i),
    .reg_addr_i       (reg_addr_i),
    .reg_wdata_i      (reg_wdata_i),
    .frame_sw_valid_i (frame_sw_valid_i),
    .frame_sw_i       (frame_sw_i),
    .reg_rdata_o      (reg_rdata_o),
    .reg_rvalid_o     (reg_rvalid_o),
    .conv_ch4_load_i  (conv_ch4_load_i),
    .conv_ch4_code_i  (conv_ch4_code_i),
    .conv_vs_load_i   (conv_vs_load_i),
    .conv_vs_code_i   (conv_vs_code_i),
    .chan_enable_o    (chan_enable_o),
    .lamp_drive_o     (lamp_drive_o)
  );
  ssl_host u_host (.mclk_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .req_o(reg_req_i), .we_o(reg_we_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .fsv_o(frame_sw_valid_i), .fsw_o(frame_sw_i));
  // Compare and count
  task automatic check(string n, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence; one idle cycle between requests, two where the results are loaded
  initial
  begin
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    check("chan", 8'h00, {4'h0, chan_enable_o});
    check("lamp", 8'h00, {4'h0, lamp_drive_o});
    for (int a = 32'h1a; a <= 32'h1e; a++)
    begin
      u_host.xfer(1'b0, a[7:0], 8'h00, 5'h00, q);
      check("reset read", 8'h00, q);
    end
    // Load results, then move the codes so only the held copy is right
    conv_ch4_code_i = 8'ha5;
    conv_vs_code_i = 10'h2b7;
    exp = '{conv_ch4_code_i, conv_vs_code_i[9:2], {6'h0, conv_vs_code_i[1:0]}};
    {conv_ch4_load_i, conv_vs_load_i} = 2'b11;
    @(negedge mclk_i);
    {conv_ch4_load_i, conv_vs_load_i} = 2'b00;
    conv_ch4_code_i = 8'h5a;
    conv_vs_code_i = 10'h148;
    for (int i = 0; i < 3; i++)
    begin
      u_host.xfer(1'b1, SSL_OFS_CH4_VOLT + 8'(i), 8'hff, 5'h1f, q);
      u_host.xfer(1'b0, SSL_OFS_CH4_VOLT + 8'(i), 8'h00, 5'h00, q);
      check("result", exp[i], q);
    end
    check("frame bits", 8'h0f, {4'h0, chan_enable_o});
    u_host.xfer(1'b1, SSL_OFS_OUTPUT_SWITCH_STATE, 8'ha6, 5'h19, q);
    check("switch", 8'h06, {4'h0, chan_enable_o});
    u_host.xfer(1'b0, SSL_OFS_OUTPUT_SWITCH_STATE, 8'h00, 5'h00, q);
    check("switch read", 8'h06, q);
    u_host.xfer(1'b1, SSL_OFS_LAMP_CTL, 8'h59, 5'h00, q);
    check("lamp", 8'h09, {4'h0, lamp_drive_o});
    u_host.xfer(1'b0, SSL_OFS_LAMP_CTL, 8'h00, 5'h00, q);
    check("lamp read", 8'h09, q);
    u_host.xfer(1'b1, 8'h30, 8'hff, 5'h00, q);
    u_host.xfer(1'b0, 8'h30, 8'h00, 5'h00, q);
    check("unmapped", 8'h00, q);
    check("switch kept", 8'h69, {chan_enable_o, lamp_drive_o});
    report_and_stop();
  end
endmodule
bind ssl_regs ssl_regs_asserts u_chk (
  .mclk_i           (mclk_i),
  .rst_i            (rst_i),
  .reg_req_i        (reg_req_i),
  .reg_we_i         (reg_we_i),
  .reg_addr_i       (reg_addr_i),
  .reg_wdata_i      (reg_wdata_i),
  .frame_sw_valid_i (frame_sw_valid_i),
  .frame_sw_i       (frame_sw_i),
  .reg_rdata_o      (reg_rdata_o),
  .reg_rvalid_o     (reg_rvalid_o),
  .chan_enable_o    (chan_enable_o),
  .lamp_drive_o     (lamp_drive_o)
);
